/* verilog/ctc_pkg.sv */
// Constants, register map and types shared by the clamp timing and output control block
package ctc_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CLAMP_START_DELAY = 8'h08;
	localparam logic [7:0] REG_CLAMP_LENGTH      = 8'h09;
	localparam logic [7:0] REG_GENERAL_CONTROL   = 8'h0a;
	localparam logic [7:0] REG_GENERAL_CONTROL_2 = 8'h0d;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_CLAMP_START_DELAY = 8'h80;
	localparam logic [7:0] RST_CLAMP_LENGTH      = 8'h80;
	localparam logic [7:0] RST_GENERAL_CONTROL   = 8'hf4;
	localparam logic       RST_FIRST_PIXEL_PORT  = 1'b0;

	// ----------------------------------------------------------------
	// General control field positions
	// ----------------------------------------------------------------
	localparam int BIT_OUTPUT_PORT_SPLIT   = 7;
	localparam int BIT_ALIGNED_TIMING      = 6;
	localparam int BIT_LINE_SYNC_POLARITY  = 5;
	localparam int BIT_HOLD_POLARITY       = 4;
	localparam int BIT_CLAMP_SOURCE_SELECT = 3;
	localparam int BIT_EXT_CLAMP_POLARITY  = 2;
	localparam int BIT_CLOCK_SOURCE_SELECT = 1;
	localparam logic [7:0] MASK_GENERAL_CONTROL = 8'hfe;

	// First pixel port bit: written at bit 4, read back at bit 7
	localparam int BIT_FIRST_PIXEL_WR = 4;
	localparam int BIT_FIRST_PIXEL_RD = 7;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CTC_CLAMP_IDLE = 2'b00,
		CTC_CLAMP_WAIT = 2'b01,
		CTC_CLAMP_ON   = 2'b11
	} ctc_clamp_state_t;

endpackage

/* verilog/ctc_clamp_if.sv */
// Carrier between the control top and the internal clamp generator
`timescale 1ns/10ps
`default_nettype none
interface ctc_clamp_if;
	logic [7:0] start_delay;
	logic [7:0] length;
	logic       enable;
	logic       trail;
	logic       clamp_on;

	modport ctrl (output start_delay, output length, output enable, output trail, input clamp_on);
	modport gen  (input start_delay, input length, input enable, input trail, output clamp_on);
endinterface
`default_nettype wire

/* verilog/ctc_clamp_gen.sv */
// Internal clamp window generator counted in pixel periods
`timescale 1ns/10ps
`default_nettype none
module ctc_clamp_gen
	import ctc_pkg::*;
(
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic srst,
	// Settings and sync event
	ctc_clamp_if.gen  cif
);

	typedef struct packed {
		ctc_clamp_state_t state;
		logic [7:0]       cnt;
	} ctc_gen_state_t;

	ctc_gen_state_t r;
	ctc_gen_state_t next_r;

	// ----------------------------------------------------------------
	// Window sequencer
	// ----------------------------------------------------------------
	// While enabled, a fresh trailing edge restarts the window, even mid-clamp; disabled, it stays idle
	always_comb begin
		next_r = r;
		if (!cif.enable) begin
			next_r.state = CTC_CLAMP_IDLE;
			next_r.cnt   = 8'h00;
		end else if (cif.trail) begin
			next_r.state = CTC_CLAMP_WAIT;
			next_r.cnt   = cif.start_delay;
		end else begin
			case (r.state)
				CTC_CLAMP_WAIT: begin
					// Zero delay is unsupported, so a count of one is the last wait cycle
					if (r.cnt <= 8'h01) begin
						next_r.state = CTC_CLAMP_ON;
						next_r.cnt   = cif.length;
					end else begin
						next_r.cnt = r.cnt - 8'h01;
					end
				end
				CTC_CLAMP_ON: begin
					if (r.cnt <= 8'h01) begin
						next_r.state = CTC_CLAMP_IDLE;
						next_r.cnt   = 8'h00;
					end else begin
						next_r.cnt = r.cnt - 8'h01;
					end
				end
				default: begin
					next_r.state = CTC_CLAMP_IDLE;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			r <= '{state: CTC_CLAMP_IDLE, cnt: 8'h00};
		end else begin
			r <= next_r;
		end
	end

	assign cif.clamp_on = (r.state == CTC_CLAMP_ON);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_start_after_delay: assert property (@(posedge clk_sys) disable iff (srst)
		(cif.trail && cif.enable && cif.start_delay == 8'h08)
		##1 (!cif.trail && cif.enable && !cif.clamp_on)[*8] |=> cif.clamp_on)
		else $error("clamp did not start eight cycles after the wait began");

	a_length_window: assert property (@(posedge clk_sys) disable iff (srst)
		($rose(cif.clamp_on) && cif.length == 8'h01 && !cif.trail) |=> !cif.clamp_on)
		else $error("clamp window did not last exactly the set length");

	a_ext_idle: assert property (@(posedge clk_sys) disable iff (srst)
		!cif.enable |=> (r.state == CTC_CLAMP_IDLE))
		else $error("internal clamp sequencer ran while external source selected");

endmodule
`default_nettype wire

/* verilog/ctc_pair_buf.sv */
// Two-entry pixel buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module ctc_pair_buf #(
	parameter int DW = 8
) (
	// Clock and reset
	input  wire logic          clk_sys,
	input  wire logic          srst,
	// Filling side
	input  wire logic [DW-1:0] in_data,
	input  wire logic          in_valid,
	output logic               in_ready,
	// Draining side
	output logic [DW-1:0]      out_data,
	output logic               out_valid,
	input  wire logic          out_ready
);

	typedef struct packed {
		logic [1:0][DW-1:0] mem;
		logic               wp;
		logic               rp;
		logic [1:0]         cnt;
	} ctc_buf_state_t;

	ctc_buf_state_t r;
	ctc_buf_state_t next_r;
	logic           push;
	logic           pop;

	// Honest flags: full at two words, empty at none
	assign in_ready  = (r.cnt != 2'd2);
	assign out_valid = (r.cnt != 2'd0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = r.mem[r.rp];

	// Pointer and occupancy update
	always_comb begin
		next_r = r;
		if (push) begin
			next_r.mem[r.wp] = in_data;
			next_r.wp        = ~r.wp;
		end
		if (pop) begin
			next_r.rp = ~r.rp;
		end
		if (push && !pop) begin
			next_r.cnt = r.cnt + 2'd1;
		end else if (pop && !push) begin
			next_r.cnt = r.cnt - 2'd1;
		end
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	a_no_overflow: assert property (@(posedge clk_sys) disable iff (srst)
		(r.cnt == 2'd2 && !pop) |=> (r.cnt == 2'd2 && $stable(r.mem)))
		else $error("full buffer lost or overwrote a word");

endmodule
`default_nettype wire

/* verilog/ctc_top.sv */
// Clamp timing, sync polarity and pixel output port control top
//
// Contract
// - Internal clamp starts clamp start delay pixel periods after sync trailing edge.
// - Internal clamp lasts clamp length pixel periods, then drops.
// - External clamp source makes the delay and length settings irrelevant.
// - Clamp start delay and clamp length both reset to 80h.
// - Split bit clear sends every pixel to A; set alternates A and B.
// - With split clear, port B pins are released (high impedance).
// - Aligned timing holds A data so one data clock edge latches both ports.
// - Aligned timing clear presents pixels on the two ports alternately.
// - Single-port mode ignores the aligned timing bit.
// - Sync polarity clear: leading edge falls, clamp counts from the rise.
// - Sync polarity set: leading edge rises, clamp counts from the fall.
// - While hold input is active, loop ignores line sync; polarity bit sets level.
// - External clamp source clamps all channels while clamp input is active.
// - External clamp polarity bit selects active low (0) or active high (1).
// - Clock source bit selects loop clock (0) or external clock input (1).
// - General control resets to split, aligned, sync, hold, clamp polarity set.
// - In two-port mode first pixel after sync leading edge goes A (0) or B (1).
`timescale 1ns/10ps
`default_nettype none
module ctc_top
	import ctc_pkg::*;
#(
	parameter int DW = 8
) (
	// Clock and reset
	input  wire logic          clk_sys,
	input  wire logic          srst,
	// Decoded register access from the serial port
	input  wire logic [7:0]    reg_addr,
	input  wire logic          reg_wr,
	input  wire logic [7:0]    reg_wdata,
	output logic [7:0]         reg_rdata,
	// Video timing pins
	input  wire logic          line_sync,
	input  wire logic          frequency_hold_input,
	input  wire logic          ext_clamp_in,
	// Digitised pixels from the converter
	input  wire logic [DW-1:0] pix_in_data,
	input  wire logic          pix_in_valid,
	output logic               pix_in_ready,
	// Output ports toward the scaler
	input  wire logic          out_ready,
	output logic [DW-1:0]      port_a_data,
	output logic [DW-1:0]      port_b_data,
	output logic               port_b_oe,
	output logic               output_data_clock,
	// Analog front end and clock generator control
	output logic               clamp_out,
	output logic               loop_ref_edge,
	output logic               loop_hold,
	output logic               clock_source_select
);

	typedef struct packed {
		logic [7:0]    clamp_start_delay;
		logic [7:0]    clamp_length;
		logic [7:0]    general_control_one;
		logic          first_pixel_port_select;
		logic [7:0]    rdata;
		logic          ls_s1;
		logic          ls_s2;
		logic          ls_prev;
		logic          hold_s1;
		logic          hold_s2;
		logic          ec_s1;
		logic          ec_s2;
		logic          ext_act;
		logic          clamp;
		logic          loop_ref;
		logic          hold;
		logic [DW-1:0] port_a;
		logic [DW-1:0] port_b;
		logic [DW-1:0] pend;
		logic          pend_b;
		logic          half;
		logic          sel_b;
		logic          dclk;
	} ctc_top_state_t;

	ctc_top_state_t r;
	ctc_top_state_t next_r;

	ctc_clamp_if    cif ();

	logic [DW-1:0]  buf_data;
	logic           buf_valid;
	logic           pop;
	logic           sync_rise;
	logic           sync_fall;
	logic           lead;
	logic           trail;
	logic           hold_act;
	logic           split;
	logic           aligned;
	logic           cur_sel;

	// ----------------------------------------------------------------
	// Sync edge decoding
	// ----------------------------------------------------------------
	// Edges are taken only from the second synchroniser stage onward
	assign sync_rise = r.ls_s2 && !r.ls_prev;
	assign sync_fall = !r.ls_s2 && r.ls_prev;
	assign lead      = r.general_control_one[BIT_LINE_SYNC_POLARITY] ? sync_rise : sync_fall;
	assign trail     = r.general_control_one[BIT_LINE_SYNC_POLARITY] ? sync_fall : sync_rise;
	assign hold_act  = (r.hold_s2 == r.general_control_one[BIT_HOLD_POLARITY]);
	assign split     = r.general_control_one[BIT_OUTPUT_PORT_SPLIT];
	assign aligned   = r.general_control_one[BIT_ALIGNED_TIMING];

	// ----------------------------------------------------------------
	// Clamp generator hookup
	// ----------------------------------------------------------------
	assign cif.start_delay = r.clamp_start_delay;
	assign cif.length      = r.clamp_length;
	assign cif.enable      = !r.general_control_one[BIT_CLAMP_SOURCE_SELECT];
	assign cif.trail       = trail;

	ctc_clamp_gen u_clamp (
		.clk_sys (clk_sys),
		.srst    (srst),
		.cif     (cif)
	);

	// ----------------------------------------------------------------
	// Pixel buffer
	// ----------------------------------------------------------------
	// Downstream stall backs up into the converter through pix_in_ready
	ctc_pair_buf #(.DW(DW)) u_buf (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.in_data   (pix_in_data),
		.in_valid  (pix_in_valid),
		.in_ready  (pix_in_ready),
		.out_data  (buf_data),
		.out_valid (buf_valid),
		.out_ready (out_ready)
	);

	assign pop = buf_valid && out_ready;

	// Phase restarts on a leading edge, even if a pixel leaves in that cycle
	assign cur_sel = lead ? r.first_pixel_port_select : r.sel_b;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		next_r = r;

		// Two-stage synchronisers for the asynchronous pins
		next_r.ls_s1   = line_sync;
		next_r.ls_s2   = r.ls_s1;
		next_r.ls_prev = r.ls_s2;
		next_r.hold_s1 = frequency_hold_input;
		next_r.hold_s2 = r.hold_s1;
		next_r.ec_s1   = ext_clamp_in;
		next_r.ec_s2   = r.ec_s1;

		// Register writes; reserved bit 0 of general control stays clear
		if (reg_wr) begin
			case (reg_addr)
				REG_CLAMP_START_DELAY: next_r.clamp_start_delay = reg_wdata;
				REG_CLAMP_LENGTH:      next_r.clamp_length = reg_wdata;
				REG_GENERAL_CONTROL:   next_r.general_control_one = reg_wdata & MASK_GENERAL_CONTROL;
				REG_GENERAL_CONTROL_2: next_r.first_pixel_port_select = reg_wdata[BIT_FIRST_PIXEL_WR];
				default:               next_r.rdata = r.rdata;
			endcase
		end

		// Read data follows the address one cycle later; unmapped reads give zero
		case (reg_addr)
			REG_CLAMP_START_DELAY: next_r.rdata = r.clamp_start_delay;
			REG_CLAMP_LENGTH:      next_r.rdata = r.clamp_length;
			REG_GENERAL_CONTROL:   next_r.rdata = r.general_control_one;
			REG_GENERAL_CONTROL_2: next_r.rdata = {r.first_pixel_port_select, 7'h00};
			default:               next_r.rdata = 8'h00;
		endcase

		// External clamp is active at the level chosen by the polarity bit
		next_r.ext_act = (r.ec_s2 == r.general_control_one[BIT_EXT_CLAMP_POLARITY]);
		if (r.general_control_one[BIT_CLAMP_SOURCE_SELECT]) begin
			next_r.clamp = r.ext_act;
		end else begin
			next_r.clamp = cif.clamp_on;
		end

		// Loop reference is withheld while the hold input is active
		next_r.loop_ref = lead && !hold_act;
		next_r.hold     = hold_act;

		// Output steering
		if (lead) begin
			next_r.sel_b = r.first_pixel_port_select;
			next_r.half  = 1'b0;
		end
		if (pop) begin
			if (!split) begin
				next_r.port_a = buf_data;
				next_r.dclk   = ~r.dclk;
				next_r.half   = 1'b0;
			end else if (!aligned) begin
				// Each pixel shows on its own port as soon as it is taken
				if (cur_sel) begin
					next_r.port_b = buf_data;
				end else begin
					next_r.port_a = buf_data;
				end
				next_r.dclk  = ~r.dclk;
				next_r.sel_b = ~cur_sel;
			end else begin
				// First of a pair waits so both ports change on the same edge
				if (!(r.half && !lead)) begin
					next_r.pend   = buf_data;
					next_r.pend_b = cur_sel;
					next_r.half   = 1'b1;
				end else begin
					if (r.pend_b) begin
						next_r.port_b = r.pend;
						next_r.port_a = buf_data;
					end else begin
						next_r.port_a = r.pend;
						next_r.port_b = buf_data;
					end
					next_r.dclk = ~r.dclk;
					next_r.half = 1'b0;
				end
				next_r.sel_b = ~cur_sel;
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			r                         <= '0;
			r.clamp_start_delay       <= RST_CLAMP_START_DELAY;
			r.clamp_length            <= RST_CLAMP_LENGTH;
			r.general_control_one     <= RST_GENERAL_CONTROL;
			r.first_pixel_port_select <= RST_FIRST_PIXEL_PORT;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata           = r.rdata;
	assign port_a_data         = r.port_a;
	assign port_b_data         = r.port_b;
	assign port_b_oe           = split;
	assign output_data_clock   = r.dclk;
	assign clamp_out           = r.clamp;
	assign loop_ref_edge       = r.loop_ref;
	assign loop_hold           = r.hold;
	assign clock_source_select = r.general_control_one[BIT_CLOCK_SOURCE_SELECT];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_clamp_reset_values: assert property (@(posedge clk_sys)
		($past(srst) && !srst) |-> (r.clamp_start_delay == 8'h80 && r.clamp_length == 8'h80))
		else $error("clamp settings not at 80h after reset");

	a_control_reset_value: assert property (@(posedge clk_sys)
		($past(srst) && !srst) |-> (r.general_control_one == 8'hf4 && !port_b_oe == 1'b0))
		else $error("general control not at its power-up value");

	a_port_b_release: assert property (@(posedge clk_sys) disable iff (srst)
		!r.general_control_one[BIT_OUTPUT_PORT_SPLIT] |-> (!port_b_oe ##1 $stable(port_b_data)))
		else $error("port B driven in single-port mode");

	a_single_port_a: assert property (@(posedge clk_sys) disable iff (srst)
		(pop && !split && !reg_wr) |=> (port_a_data == $past(buf_data) && $stable(port_b_data)))
		else $error("single-port pixel did not land on port A");

	a_alternate_ports: assert property (@(posedge clk_sys) disable iff (srst)
		(pop && split && !aligned && cur_sel) |=> (port_b_data == $past(buf_data) && $stable(port_a_data)))
		else $error("alternating pixel not presented on port B alone");

	a_aligned_hold: assert property (@(posedge clk_sys) disable iff (srst)
		(pop && split && aligned && !(r.half && !lead)) |=> ($stable(output_data_clock) && $stable(port_a_data)))
		else $error("aligned mode changed ports on the first pixel of a pair");

	a_first_pixel_phase: assert property (@(posedge clk_sys) disable iff (srst)
		(lead && !pop) |=> (r.sel_b == $past(r.first_pixel_port_select) && !r.half))
		else $error("pixel phase not restarted on sync leading edge");

	a_trail_polarity: assert property (@(posedge clk_sys) disable iff (srst)
		trail |-> (r.ls_s2 != r.general_control_one[BIT_LINE_SYNC_POLARITY]
			&& r.ls_prev == r.general_control_one[BIT_LINE_SYNC_POLARITY]))
		else $error("clamp counted from the wrong sync edge");

	a_hold_gates_loop: assert property (@(posedge clk_sys) disable iff (srst)
		$past(hold_act) |-> (!loop_ref_edge && loop_hold))
		else $error("loop reference passed while hold was active");

	a_ext_clamp_follow: assert property (@(posedge clk_sys) disable iff (srst)
		($past(r.general_control_one, 1) == $past(r.general_control_one, 2)
			&& $past(r.general_control_one[BIT_CLAMP_SOURCE_SELECT]))
		|-> (clamp_out == ($past(r.ec_s2, 2) == $past(r.general_control_one[BIT_EXT_CLAMP_POLARITY], 2))))
		else $error("external clamp did not follow the clamp input");

endmodule
`default_nettype wire

/* testbench/ctc_sink_model.sv */
// Downstream scaler model: paces the output and logs both ports on each data clock change
`timescale 1ns/10ps
`default_nettype none
module ctc_sink_model #(
	parameter int DW = 8
) (
	// Clock and reset
	input  wire logic          clk_sys,
	input  wire logic          srst,
	// Ports of the block
	input  wire logic [DW-1:0] port_a_data,
	input  wire logic [DW-1:0] port_b_data,
	input  wire logic          port_b_oe,
	input  wire logic          output_data_clock,
	// Pace: 0 prompt, 1 every other cycle, 2 stalled
	input  wire logic [1:0]    pace,
	output logic               out_ready
);
	logic          seen = 1'b0;
	logic          odd  = 1'b0;
	logic [DW-1:0] la[$];
	logic [DW-1:0] lb[$];

	// Log on each level change; a missed toggle shows up as a short log, not a wrong value
	always @(posedge clk_sys) begin
		seen <= srst ? 1'b0 : output_data_clock;
		odd <= ~odd & ~srst;
		out_ready <= srst || (pace == 2'd0) || (pace == 2'd1 && odd);
		if (!srst && output_data_clock !== seen) begin
			la.push_back(port_a_data);
			lb.push_back(port_b_oe ? port_b_data : ~port_b_data);
		end
	end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench for the clamp timing and output control block
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import ctc_pkg::*;
;
	logic       clk_sys = 1'b0;
	logic       srst    = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic       reg_wr   = 1'b0;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic       line_sync = 1'b0;
	logic       frequency_hold_input = 1'b0;
	logic       ext_clamp_in = 1'b0;
	logic [7:0] pix_in_data = 8'h00;
	logic       pix_in_valid = 1'b0;
	logic       pix_in_ready, out_ready, port_b_oe, output_data_clock;
	logic [7:0] port_a_data, port_b_data;
	logic       clamp_out, loop_ref_edge, loop_hold, clock_source_select;
	logic [1:0] pace = 2'd0;
	logic [7:0] v, n, d1, d8;
	int         fail_count = 0, checked = 0, cycles = 0, ref_cnt = 0, r0, m, k;
	logic [7:0] ra[5] = '{8'h08, 8'h09, 8'h0a, 8'h0d, 8'h0e};
	logic [7:0] re[5] = '{8'h80, 8'h80, 8'hf4, 8'h00, 8'h00};

	ctc_top #(.DW(8)) DUT (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .line_sync(line_sync),
		.frequency_hold_input(frequency_hold_input), .ext_clamp_in(ext_clamp_in),
		.pix_in_data(pix_in_data), .pix_in_valid(pix_in_valid), .pix_in_ready(pix_in_ready),
		.out_ready(out_ready), .port_a_data(port_a_data), .port_b_data(port_b_data),
		.port_b_oe(port_b_oe), .output_data_clock(output_data_clock), .clamp_out(clamp_out),
		.loop_ref_edge(loop_ref_edge), .loop_hold(loop_hold), .clock_source_select(clock_source_select));
	ctc_sink_model #(.DW(8)) SINK (.clk_sys(clk_sys), .srst(srst), .port_a_data(port_a_data),
		.port_b_data(port_b_data), .port_b_oe(port_b_oe), .output_data_clock(output_data_clock),
		.pace(pace), .out_ready(out_ready));

	// ----------------------------------------------------------------
	// Clock, watchdog and helpers
	// ----------------------------------------------------------------
	always #12.5 clk_sys = ~clk_sys;

	// Count loop reference pulses; a hang is cut short as a mismatch
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (loop_ref_edge === 1'b1)
			ref_cnt <= ref_cnt + 1;
		if (cycles == 20000) begin
			fail_count++;
			close_out();
		end
	end

	task automatic close_out();
		if (fail_count == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Strobe is dropped and an edge passes, so back-to-back writes never overlap
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr <= a;
		repeat (3) @(posedge clk_sys);
		d = reg_rdata;
	endtask

	task automatic pulse(input logic act, output logic [7:0] dly, output logic [7:0] len);
		line_sync <= act;
		repeat (6) @(posedge clk_sys);
		line_sync <= ~act;
		dly = 8'h00;
		len = 8'h00;
		while (clamp_out !== 1'b1 && dly < 8'd200) begin
			@(posedge clk_sys);
			dly++;
		end
		while (clamp_out === 1'b1 && len < 8'd200) begin
			@(posedge clk_sys);
			len++;
		end
	endtask

	// Valid stays up across the burst; each word waits for ready
	task automatic burst(input logic [7:0] b, input int cnt);
		for (int i = 0; i < cnt; i++) begin
			pix_in_data <= b + 8'(i);
			pix_in_valid <= 1'b1;
			do @(posedge clk_sys); while (pix_in_ready !== 1'b1);
		end
		pix_in_valid <= 1'b0;
		repeat (6) @(posedge clk_sys);
	endtask

	initial begin
		repeat (16) @(posedge clk_sys);
		srst <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			rd(ra[i], v);
			chk(v, re[i]);
		end
		wr(REG_GENERAL_CONTROL, 8'hff);
		rd(REG_GENERAL_CONTROL, v);
		chk(v, 8'hfe);
		chk(8'(clock_source_select), 8'h01);
		wr(REG_GENERAL_CONTROL, 8'hf4);
		wr(REG_CLAMP_START_DELAY, 8'h01);
		wr(REG_CLAMP_LENGTH, 8'h01);
		pulse(1'b1, d1, n);
		chk(n, 8'h01);
		chk(d1, 8'h06);
		wr(REG_CLAMP_START_DELAY, 8'h08);
		wr(REG_CLAMP_LENGTH, 8'h10);
		r0 = ref_cnt;
		pulse(1'b1, d8, n);
		chk(n, 8'h10);
		chk(d8 - d1, 8'h07);
		chk(8'(ref_cnt - r0), 8'h01);
		wr(REG_GENERAL_CONTROL, 8'hd4);
		line_sync <= 1'b1;
		repeat (40) @(posedge clk_sys);
		pulse(1'b0, v, n);
		chk(v, d8);
		wr(REG_GENERAL_CONTROL, 8'hf4);
		line_sync <= 1'b0;
		frequency_hold_input <= 1'b1;
		repeat (40) @(posedge clk_sys);
		r0 = ref_cnt;
		pulse(1'b1, v, n);
		chk(8'(loop_hold), 8'h01);
		chk(8'(ref_cnt - r0), 8'h00);
		wr(REG_GENERAL_CONTROL, 8'he4);
		repeat (4) @(posedge clk_sys);
		chk(8'(loop_hold), 8'h00);
		// External clamp: every polarity against every pin level
		for (int i = 0; i < 4; i++) begin
			wr(REG_GENERAL_CONTROL, i[1] ? 8'hfc : 8'hf8);
			ext_clamp_in <= i[0];
			repeat (5) @(posedge clk_sys);
			chk(8'(clamp_out), 8'(i[0] == i[1]));
		end
		frequency_hold_input <= 1'b0;
		ext_clamp_in <= 1'b0;
		pulse(1'b1, v, n);
		chk(v, 8'd200);
		for (int i = 0; i < 2; i++) begin
			wr(REG_GENERAL_CONTROL, i[0] ? 8'h34 : 8'h74);
			m = SINK.la.size();
			burst(8'h10, 3);
			chk(8'(SINK.la.size() - m), 8'h03);
			chk(SINK.la[m + 2], 8'h12);
			chk(8'(port_b_oe), 8'h00);
		end
		// Two-port modes with both first-pixel choices; a lead edge restarts the pairing
		for (int i = 0; i < 4; i++) begin
			wr(REG_GENERAL_CONTROL, i[1] ? 8'hf4 : 8'hb4);
			wr(REG_GENERAL_CONTROL_2, i[0] ? 8'h10 : 8'h00);
			pulse(1'b1, v, n);
			m = SINK.la.size();
			burst(8'h20, 2);
			chk(8'(SINK.la.size() - m), i[1] ? 8'h01 : 8'h02);
			k = m + (i[1] ? 0 : 1);
			chk(i[0] ? SINK.lb[m] : SINK.la[m], 8'h20);
			chk(i[0] ? SINK.la[k] : SINK.lb[k], 8'h21);
		end
		rd(REG_GENERAL_CONTROL_2, v);
		chk(v, 8'h80);
		// Stalled receiver: the buffer takes two words, then drains slowly with no loss
		wr(REG_GENERAL_CONTROL, 8'h74);
		pace <= 2'd2;
		repeat (3) @(posedge clk_sys);
		m = SINK.la.size();
		n = 8'h00;
		pix_in_data <= 8'h40;
		pix_in_valid <= 1'b1;
		repeat (8) begin
			@(posedge clk_sys);
			if (pix_in_ready === 1'b1) begin
				n++;
				pix_in_data <= 8'h40 + n;
			end
		end
		pix_in_valid <= 1'b0;
		chk(n, 8'h02);
		pace <= 2'd1;
		repeat (12) @(posedge clk_sys);
		chk(8'(SINK.la.size() - m), 8'h02);
		chk(SINK.la[m + 1], 8'h41);
		close_out();
	end
endmodule
`default_nettype wire
